// ==== simd_fp_cfg.svh ====
// Purpose: Bit positions, reset values and widths of the SIMD floating-point control word.
// Assumes: Single-precision operands, 32-bit control word.
// Notes:   Definitions only; included by bare name.
`ifndef SIMD_FP_CFG_SVH
`define SIMD_FP_CFG_SVH

`define CSR_W        32
`define FLAG_LSB     0
`define FLAG_MSB     5
`define ZAI_BIT      6
`define MASK_LSB     7
`define MASK_MSB     12
`define ROUND_LSB    13
`define ROUND_MSB    14
`define FLUSH_BIT    15
`define RSV_LSB      16
`define RSV_MSB      31
`define EXC_N        6
`define IDX_INV      0
`define IDX_DEN      1
`define IDX_UND      4
`define IDX_PRE      5
`define CSR_RESET    32'h0000_1f80
`define WMASK_FULL   32'h0000_ffff
`define WMASK_NO_ZAI 32'h0000_ffbf
`define WMASK_NONE   32'h0000_0000
`define FP_W         32
`define FP_SIGN      31
`define FP_EXP_MSB   30
`define FP_EXP_LSB   23
`define FP_FRAC_MSB  22

`endif

// ==== simd_fp_pkg.sv ====
// Purpose: Types shared by the SIMD floating-point control word and its helpers.
// Assumes: Encodings follow declaration order.
// Notes:   Numbers live in simd_fp_cfg.svh.
`include "simd_fp_cfg.svh"
package simd_fp_pkg;

  // Rounding selection in field order: nearest even, down, up, toward zero.
  typedef enum logic [1:0] {round_nearest, round_down, round_up, round_zero} round_type;

  // Which instruction writes the control word.
  typedef enum logic {wr_load, wr_restore} wr_kind_type;

  // Which instruction reads the control word.
  typedef enum logic {rd_store, rd_save} rd_kind_type;

  // Whole state of the control word block except the registered operands.
  typedef struct packed {
    logic [`CSR_W-1:0] csr;
    logic              wr_done;
    logic              wr_fault;
    logic              rd_done;
    logic [`CSR_W-1:0] rd_data;
    logic [`CSR_W-1:0] rd_wmask;
    logic              raise;
    logic              res_valid;
    logic [`FP_W-1:0]  res_data;
  } csr_state_type;

endpackage

// ==== operand_zeroer.sv ====
// Purpose: Replaces denormal source operands by a zero of the same sign.
// Assumes: Lanes are packed single-precision values.
// Notes:   Purely combinational; the caller registers the result.
`timescale 1ns/10ps
`include "simd_fp_cfg.svh"
module operand_zeroer #(
  parameter int LANES = 4 // Operand lanes.
) (
  input  wire logic [LANES*`FP_W-1:0] op_in,  // Raw operands.
  input  wire logic                   enable, // Zero abnormal inputs.
  output logic      [LANES*`FP_W-1:0] op_out  // Filtered operands.
);

  // One filter per lane; a denormal has a zero exponent and a non-zero fraction.
  for (genvar i = 0; i < LANES; i++) begin : g_lane
    logic [`FP_W-1:0] v;
    logic             denorm;
    assign v      = op_in[i*`FP_W +: `FP_W];
    assign denorm = (v[`FP_EXP_MSB:`FP_EXP_LSB] == '0) && (v[`FP_FRAC_MSB:0] != '0);
    assign op_out[i*`FP_W +: `FP_W] = (enable && denorm) ?
                                      {v[`FP_SIGN], {(`FP_W-1){1'b0}}} : v; // [RULE15]
  end

endmodule

// ==== exc_resolver.sv ====
// Purpose: Turns detected exception conditions into flag sets and a raise decision.
// Assumes: Detections come from one instruction at a time.
// Notes:   Combinational.
`timescale 1ns/10ps
`include "simd_fp_cfg.svh"
module exc_resolver (
  input  wire logic              ex_valid, // Instruction reports conditions.
  input  wire logic [`EXC_N-1:0] detect,   // Detected conditions.
  input  wire logic [`EXC_N-1:0] masks,    // Mask bits, set suppresses.
  input  wire logic              zero_inputs, // Zero abnormal inputs mode.
  input  wire logic              flush_en,    // Flush underflow mode.
  output logic      [`EXC_N-1:0] set_flags, // Flags to set.
  output logic                   raise,     // Unmasked exception found.
  output logic                   flush      // Underflow result goes to zero.
);

  logic [`EXC_N-1:0] det;

  // Abnormal input never counts while operands are zeroed; flush only when masked.
  always_comb begin
    det = detect;
    if (zero_inputs) begin
      det[`IDX_DEN] = 1'b0; // [RULE16]
    end
    flush = ex_valid && flush_en && masks[`IDX_UND] && det[`IDX_UND]; // [RULE11] [RULE13]
    if (flush) begin
      det[`IDX_PRE] = 1'b1; // [RULE12]
    end
    set_flags = ex_valid ? det : '0;
    raise     = ex_valid && ((det & ~masks) != '0); // [RULE5] [RULE8]
  end

endmodule

// ==== simd_fp_ctrl_status_reg.sv ====
// Purpose: Control and status word of the SIMD floating-point unit.
// Assumes: Software access arrives as one-cycle load/store requests from the sequencer.
// Notes:   Answers arrive one cycle after each request; datapath sees the held value.
`timescale 1ns/10ps
`include "simd_fp_cfg.svh"

// Functional notes
// RULE1 - Bits 16-31 reserved, zero after reset.
// RULE2 - Non-zero reserved write raises protection fault.
// RULE3 - Flags 0-5 sticky until software writes zero.
// RULE4 - Flag and mask bit order fixed.
// RULE5 - Set mask suppresses its exception.
// RULE6 - All masks set after reset.
// RULE7 - Write unmasking a set flag raises nothing.
// RULE8 - Raise only on later detected condition.
// RULE9 - Bits 13-14 drive rounding to datapath.
// RULE10 - Rounding encoding: nearest, down, up, zero.
// RULE11 - Masked underflow with flush gives signed zero.
// RULE12 - Flushed underflow sets precision and underflow.
// RULE13 - Flush ignored while underflow unmasked.
// RULE14 - Flush mode cleared at reset.
// RULE15 - Abnormal-input mode zeroes denormal operands.
// RULE16 - Abnormal-input mode never flags abnormal input.
// RULE17 - Abnormal-input mode cleared at reset.
// RULE18 - Without the feature, setting bit 6 faults.
// RULE19 - Full save reports writable bits mask.
// RULE20 - Load/restore write, store/save read.
// RULE21 - One shared instance for all instruction generations.
module simd_fp_ctrl_status_reg #(
  parameter bit ZAI_SUPPORTED = 1'b1, // Zero abnormal inputs feature present.
  parameter int LANES         = 4     // Operand lanes filtered per cycle.
) (
  input  wire logic                      clk,           // 250 MHz clock.
  input  wire logic                      reset,         // Synchronous, active high.
  input  wire logic                      wr_valid,      // Load or restore request.
  input  wire simd_fp_pkg::wr_kind_type  wr_kind,       // Which instruction writes.
  input  wire logic [`CSR_W-1:0]         wr_data,       // Word from memory.
  output logic                           wr_done,       // Write finished, pulse.
  output logic                           wr_fault,      // Protection fault, pulse.
  input  wire logic                      rd_valid,      // Store or save request.
  input  wire simd_fp_pkg::rd_kind_type  rd_kind,       // Which instruction reads.
  output logic                           rd_done,       // Read data valid, pulse.
  output logic [`CSR_W-1:0]              rd_data,       // Word to memory.
  output logic [`CSR_W-1:0]              rd_wmask,      // Writable bits, save only.
  output simd_fp_pkg::round_type         rounding_mode, // Rounding for datapath.
  output logic                           zero_abnormal_inputs, // Zero abnormal inputs active.
  output logic                           flush_mode,    // Flush underflow mode bit.
  output logic [`EXC_N-1:0]              exc_masks,     // Current mask bits.
  output logic [`EXC_N-1:0]              exc_flags,     // Current sticky flags.
  input  wire logic                      ex_valid,      // Instruction reports conditions.
  input  wire logic [`EXC_N-1:0]         ex_detect,     // Detected conditions.
  output logic                           exc_raise,     // Unmasked exception, pulse.
  input  wire logic [LANES*`FP_W-1:0]    op_in,         // Raw source operands.
  output logic [LANES*`FP_W-1:0]         op_out,        // Filtered operands, registered.
  input  wire logic                      res_valid_in,  // Result offered.
  input  wire logic [`FP_W-1:0]          res_in,        // Rounded true result.
  output logic                           res_valid,     // Result valid, pulse.
  output logic [`FP_W-1:0]               res_out        // Final result.
);

  // Every type of the block comes from the shared package.
  import simd_fp_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Parameter checks.

  // The lane count must be usable.
  if (LANES < 1) begin : g_bad_lanes
    $error("LANES must be at least one.");
  end

  // The reserved field must end at the top of the word, or bits would go unchecked.
  if (`CSR_W != `RSV_MSB + 1) begin : g_bad_width
    $error("Control word width does not match the reserved field.");
  end

  // One flag and one mask per exception, or the resolver would misalign them.
  if ((`EXC_N != `FLAG_MSB - `FLAG_LSB + 1) || (`EXC_N != `MASK_MSB - `MASK_LSB + 1)) begin : g_bad_exc
    $error("Exception count does not match the flag and mask fields.");
  end

  // The operand filter assumes the sign sits in the top bit of each lane.
  if (`FP_W != `FP_SIGN + 1) begin : g_bad_fp
    $error("Operand width does not match the sign position.");
  end

  ////////////////////////////////////////////////////////////////////////////
  // State and helpers.

  csr_state_type             st_r;
  csr_state_type             st_nxt;
  logic [LANES*`FP_W-1:0]    op_r;
  logic [LANES*`FP_W-1:0]    op_zeroed;
  logic [`EXC_N-1:0]         set_flags;
  logic                      raise;
  logic                      flush;
  logic                      bad_write;
  logic [`CSR_W-1:0]         wmask;

  // Writable bits depend on whether the abnormal-input mode exists.
  assign wmask = ZAI_SUPPORTED ? `WMASK_FULL : `WMASK_NO_ZAI; // [RULE19]

  // A write faults on any bit outside the writable set.
  assign bad_write = (wr_data[`RSV_MSB:`RSV_LSB] != '0) || // [RULE2]
                     ((wr_data & ~wmask) != '0);           // [RULE18]

  ////////////////////////////////////////////////////////////////////////////
  // Datapath helpers.

  // Denormal operands are zeroed while the mode is on.
  operand_zeroer #(
    .LANES (LANES)
  ) u_zeroer (
    .op_in  (op_in),
    .enable (st_r.csr[`ZAI_BIT]),
    .op_out (op_zeroed)
  );

  // Detected conditions become flag sets and a raise decision.
  exc_resolver u_resolver (
    .ex_valid  (ex_valid),
    .detect    (ex_detect),
    .masks     (st_r.csr[`MASK_MSB:`MASK_LSB]),
    .zero_inputs (st_r.csr[`ZAI_BIT]),
    .flush_en    (st_r.csr[`FLUSH_BIT]),
    .set_flags (set_flags),
    .raise     (raise),
    .flush     (flush)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Next state.

  // Writes replace the word; detections set flags; a set wins over a cleared bit.
  always_comb begin
    st_nxt          = st_r;
    st_nxt.wr_done  = 1'b0;
    st_nxt.wr_fault = 1'b0;
    st_nxt.rd_done  = 1'b0;
    st_nxt.res_valid = res_valid_in;
    st_nxt.raise    = raise; // [RULE7] [RULE8]
    if (wr_valid) begin
      st_nxt.wr_done  = 1'b1;
      st_nxt.wr_fault = bad_write; // [RULE2] [RULE18]
      if (!bad_write) begin
        st_nxt.csr = wr_data & wmask; // [RULE20] [RULE1]
      end
    end
    st_nxt.csr[`FLAG_MSB:`FLAG_LSB] = st_nxt.csr[`FLAG_MSB:`FLAG_LSB] | set_flags; // [RULE3]
    if (rd_valid) begin
      st_nxt.rd_done  = 1'b1;
      st_nxt.rd_data  = st_r.csr; // [RULE20]
      st_nxt.rd_wmask = (rd_kind == rd_save) ? wmask : `WMASK_NONE; // [RULE19]
    end
    if (res_valid_in) begin
      st_nxt.res_data = flush ? {res_in[`FP_SIGN], {(`FP_W-1){1'b0}}} : res_in; // [RULE11]
    end
  end

  // One register holds all state but the operands, shared by every instruction generation.
  always_ff @(posedge clk) begin // [RULE21]
    if (reset) begin
      st_r          <= '0;
      st_r.csr      <= `CSR_RESET; // [RULE6] [RULE14] [RULE17] [RULE1]
      st_r.rd_wmask <= `WMASK_NONE;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Filtered operands are registered toward the datapath.
  always_ff @(posedge clk) begin
    if (reset) begin
      op_r <= '0;
    end else begin
      op_r <= op_zeroed; // [RULE15]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs.

  // Fields of the word go straight to the datapath from the register.
  assign rounding_mode        = round_type'(st_r.csr[`ROUND_MSB:`ROUND_LSB]); // [RULE9] [RULE10]
  assign zero_abnormal_inputs = st_r.csr[`ZAI_BIT];
  assign flush_mode           = st_r.csr[`FLUSH_BIT];
  assign exc_masks     = st_r.csr[`MASK_MSB:`MASK_LSB]; // [RULE4]
  assign exc_flags     = st_r.csr[`FLAG_MSB:`FLAG_LSB]; // [RULE4]
  assign wr_done       = st_r.wr_done;
  assign wr_fault      = st_r.wr_fault;
  assign rd_done       = st_r.rd_done;
  assign rd_data       = st_r.rd_data;
  assign rd_wmask      = st_r.rd_wmask;
  assign exc_raise     = st_r.raise;
  assign res_valid     = st_r.res_valid;
  assign res_out       = st_r.res_data;
  assign op_out        = op_r;

  ////////////////////////////////////////////////////////////////////////////
  // Checks.

  a_reserved_zero: assert property (@(posedge clk) disable iff (reset) // [RULE1]
    st_r.csr[`RSV_MSB:`RSV_LSB] == '0)
    else $error("Reserved bits not zero.");

  a_fault_on_reserved: assert property (@(posedge clk) disable iff (reset) // [RULE2]
    wr_valid && (wr_data[`RSV_MSB:`RSV_LSB] != '0) |=> wr_fault && $stable(st_r.csr[`CSR_W-1:`ZAI_BIT]))
    else $error("Reserved write did not fault.");

  a_flags_sticky: assert property (@(posedge clk) disable iff (reset) // [RULE3]
    !wr_valid |=> ((exc_flags & $past(exc_flags)) == $past(exc_flags)))
    else $error("Sticky flag lost without a write.");

  a_set_beats_clear: assert property (@(posedge clk) disable iff (reset) // [RULE3]
    wr_valid && ex_valid && ex_detect[`IDX_INV] |=> exc_flags[`IDX_INV])
    else $error("Detected flag lost on clearing write.");

  a_reset_masks: assert property (@(posedge clk) // [RULE6]
    $past(reset) |-> exc_masks == '1 && !flush_mode && !zero_abnormal_inputs)
    else $error("Reset value of control word wrong.");

  a_no_raise_on_write: assert property (@(posedge clk) disable iff (reset) // [RULE7]
    !ex_valid |=> !exc_raise)
    else $error("Exception raised without detection.");

  a_masked_silent: assert property (@(posedge clk) disable iff (reset) // [RULE5]
    ex_valid && ((ex_detect & ~exc_masks) == '0) && (exc_masks[`IDX_PRE] || !flush_mode)
    |=> !exc_raise)
    else $error("Masked exception raised.");

  a_flush_zero: assert property (@(posedge clk) disable iff (reset) // [RULE11]
    res_valid_in && ex_valid && flush_mode && exc_masks[`IDX_UND] && ex_detect[`IDX_UND]
    |=> res_out == {$past(res_in[`FP_SIGN]), {(`FP_W-1){1'b0}}} && exc_flags[`IDX_PRE])
    else $error("Flushed underflow result or flags wrong.");

  a_zero_no_flag: assert property (@(posedge clk) disable iff (reset) // [RULE16]
    ex_valid && zero_abnormal_inputs && !wr_valid && !exc_flags[`IDX_DEN] && !flush_mode &&
    ((ex_detect & ~exc_masks & ~(`EXC_N'(1) << `IDX_DEN)) == '0)
    |=> !exc_flags[`IDX_DEN] && !exc_raise)
    else $error("Abnormal input flagged while zeroing.");

  a_save_wmask: assert property (@(posedge clk) disable iff (reset) // [RULE19]
    rd_valid && rd_kind == rd_save |=> rd_done ##0 rd_wmask == wmask)
    else $error("Save did not report writable mask.");

  // A plain store carries no mask, so software cannot mistake it for a save.
  a_store_no_mask: assert property (@(posedge clk) disable iff (reset) // [RULE19]
    rd_valid && rd_kind == rd_store |=> rd_wmask == `WMASK_NONE)
    else $error("Store reported a writable mask.");

  // A read answers with the word as it stood in the request cycle.
  a_read_answer: assert property (@(posedge clk) disable iff (reset) // [RULE20]
    rd_valid |=> rd_done && rd_data == $past(st_r.csr))
    else $error("Read answer wrong.");

  // An accepted write lands whole when no detection competes with it.
  a_write_lands: assert property (@(posedge clk) disable iff (reset) // [RULE20]
    wr_valid && !bad_write && !ex_valid |=> !wr_fault && st_r.csr == $past(wr_data & wmask))
    else $error("Accepted write did not land.");

  // A write with an unwritable bit is refused and changes nothing.
  a_refused_kept: assert property (@(posedge clk) disable iff (reset) // [RULE18]
    wr_valid && ((wr_data & ~wmask) != '0) && !ex_valid |=> wr_fault && $stable(st_r.csr))
    else $error("Refused write changed the word.");

  // Without the zeroing feature the mode bit can never become set.
  a_no_zero_bit: assert property (@(posedge clk) disable iff (reset) // [RULE18]
    ZAI_SUPPORTED || !zero_abnormal_inputs)
    else $error("Zeroing mode set on a part without it.");

  // Answer pulses stay low when nothing was asked.
  a_pulse_quiet: assert property (@(posedge clk) disable iff (reset) // [RULE20]
    !wr_valid && !rd_valid |=> !wr_done && !wr_fault && !rd_done)
    else $error("Answer pulse without a request.");

  // The whole word takes its reset value after any reset.
  a_reset_word: assert property (@(posedge clk) // [RULE1]
    $past(reset) |-> st_r.csr == `CSR_RESET)
    else $error("Control word not at reset value.");

  // With zeroing off, a detection that is not masked raises one cycle later.
  a_unmasked_raise: assert property (@(posedge clk) disable iff (reset) // [RULE8]
    ex_valid && !zero_abnormal_inputs && ((ex_detect & ~exc_masks) != '0) |=> exc_raise)
    else $error("Unmasked exception not raised.");

  // A flushed underflow records both underflow and precision.
  a_flush_flags: assert property (@(posedge clk) disable iff (reset) // [RULE12]
    ex_valid && flush_mode && exc_masks[`IDX_UND] && ex_detect[`IDX_UND]
    |=> exc_flags[`IDX_UND] && exc_flags[`IDX_PRE])
    else $error("Flushed underflow flags missing.");

  // With underflow unmasked the result passes untouched, whatever the flush bit.
  a_flush_ignored: assert property (@(posedge clk) disable iff (reset) // [RULE13]
    res_valid_in && !exc_masks[`IDX_UND] |=> res_out == $past(res_in))
    else $error("Result flushed while underflow unmasked.");

  // A denormal in lane zero leaves as a signed zero while zeroing is on.
  a_zero_operand: assert property (@(posedge clk) disable iff (reset) // [RULE15]
    zero_abnormal_inputs && (op_in[`FP_EXP_MSB:`FP_EXP_LSB] == '0)
    |=> op_out[`FP_SIGN-1:0] == '0 && op_out[`FP_SIGN] == $past(op_in[`FP_SIGN]))
    else $error("Denormal operand not zeroed.");

  // Operands pass untouched while zeroing is off.
  a_keep_operand: assert property (@(posedge clk) disable iff (reset) // [RULE15]
    !zero_abnormal_inputs |=> op_out == $past(op_in))
    else $error("Operand altered with zeroing off.");

endmodule

// ==== fp_datapath_model.sv ====
// Purpose: Datapath model that reports conditions, operands and results.
// Assumes: The bench calls report once per instruction.
// Notes:   Released detection and result buses show the inverse of their last value; operands hold.
`timescale 1ns/10ps
`include "simd_fp_cfg.svh"
module fp_datapath_model #(
  parameter int LANES = 4 // Operand lanes.
) (
  input  wire logic                   clk,          // Clock.
  output logic                        ex_valid,     // Conditions valid.
  output logic      [`EXC_N-1:0]      ex_detect,    // Detected conditions.
  output logic      [LANES*`FP_W-1:0] op_in,        // Source operands.
  output logic                        res_valid_in, // Result valid.
  output logic      [`FP_W-1:0]       res_in        // Rounded result.
);
  // Keep every output quiet until the first report.
  initial begin
    ex_valid     = 1'b0;
    ex_detect    = '0;
    op_in        = '0;
    res_valid_in = 1'b0;
    res_in       = '0;
  end
  // One-cycle report of conditions, result and operands.
  task automatic report(input logic [`EXC_N-1:0] det, input logic [`FP_W-1:0] res,
                        input logic [LANES*`FP_W-1:0] op);
    @(posedge clk);
    #1;
    ex_valid     = 1'b1;
    ex_detect    = det;
    res_valid_in = 1'b1;
    res_in       = res;
    op_in        = op;
    @(posedge clk);
    #1;
    ex_valid     = 1'b0;
    res_valid_in = 1'b0;
    ex_detect    = ~det; // A stale value must not pass for a fresh one.
    res_in       = ~res;
  endtask
endmodule

// ==== tb_simd_fp_ctrl_status_reg.sv ====
// Purpose: Self-checking bench for the SIMD floating-point control word.
// Assumes: Inputs change 1 ns after the rising edge.
// Notes:   A second instance lacks the abnormal-input zeroing feature.
`timescale 1ns/10ps
`include "simd_fp_cfg.svh"
module tb_simd_fp_ctrl_status_reg;
  import simd_fp_pkg::*;
  logic        clk, reset, wr_valid, rd_valid, wr_done, wr_fault, rd_done, nd_fault;
  logic        zero_abnormal_inputs, flush_mode, ex_valid, exc_raise, res_valid_in, res_valid;
  wr_kind_type wr_kind;
  rd_kind_type rd_kind;
  round_type   rounding_mode;
  logic [31:0] wr_data, rd_data, rd_wmask, nd_wmask, res_in, res_out;
  logic [5:0]  exc_masks, exc_flags, ex_detect;
  logic [127:0] op_in, op_out;
  int          err_total = 0;
  int          cmp_count = 0;
  int          cyc = 0;
  ////////////////////////////////////////////////////////////////////////////////
  simd_fp_ctrl_status_reg u_dut (.clk, .reset, .wr_valid, .wr_kind, .wr_data, .wr_done,
    .wr_fault, .rd_valid, .rd_kind, .rd_done, .rd_data, .rd_wmask, .rounding_mode,
    .zero_abnormal_inputs, .flush_mode, .exc_masks, .exc_flags, .ex_valid, .ex_detect,
    .exc_raise, .op_in, .op_out, .res_valid_in, .res_in, .res_valid, .res_out);
  simd_fp_ctrl_status_reg #(.ZAI_SUPPORTED(1'b0)) u_no_zai (.clk, .reset, .wr_valid, .wr_kind,
    .wr_data, .wr_done(), .wr_fault(nd_fault), .rd_valid, .rd_kind, .rd_done(), .rd_data(),
    .rd_wmask(nd_wmask), .rounding_mode(), .zero_abnormal_inputs(), .flush_mode(), .exc_masks(),
    .exc_flags(), .ex_valid, .ex_detect, .exc_raise(), .op_in, .op_out(), .res_valid_in,
    .res_in, .res_valid(), .res_out());
  fp_datapath_model u_dp (.clk, .ex_valid, .ex_detect, .op_in, .res_valid_in, .res_in);
  ////////////////////////////////////////////////////////////////////////////////
  // Compare one value and count it.
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_total++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Load or restore the word; the answer stands one cycle later.
  task automatic wr(input logic [31:0] d, input wr_kind_type k, input logic flt);
    @(posedge clk);
    #1;
    wr_valid = 1'b1;
    wr_kind  = k;
    wr_data  = d;
    @(posedge clk);
    #1;
    wr_valid = 1'b0;
    chk(32'(wr_done), 32'h1);
    chk(32'(wr_fault), 32'(flt));
    chk(32'(exc_raise), 32'h0);
  endtask
  // Store or save the word and compare it and the writable mask with expected values.
  task automatic rd(input rd_kind_type k, input logic [31:0] exp, input logic [31:0] wm);
    @(posedge clk);
    #1;
    rd_valid = 1'b1;
    rd_kind  = k;
    @(posedge clk);
    #1;
    rd_valid = 1'b0;
    chk(32'(rd_done), 32'h1);
    chk(rd_data, exp);
    chk(rd_wmask, wm);
  endtask
  // Print counts and verdict, then stop.
  task automatic print_verdict;
    $display("Comparisons %0d, mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // Free-running 250 MHz clock.
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // Cut a hang short.
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      err_total++;
      print_verdict();
    end
  end
  // Test sequence.
  initial begin
    reset    = 1'b1;
    wr_valid = 1'b0;
    rd_valid = 1'b0;
    wr_kind  = wr_load;
    rd_kind  = rd_store;
    wr_data  = '0;
    repeat (3) @(posedge clk);
    #1;
    reset = 1'b0;
    chk(32'({exc_masks, exc_flags}), 32'h0000_0fc0);
    chk(32'({flush_mode, zero_abnormal_inputs, rounding_mode}), 32'h0);
    rd(rd_save, 32'h0000_1f80, 32'h0000_ffff);
    chk(nd_wmask, 32'h0000_ffbf);
    $display("test reset done");
    wr(32'h0001_1f80, wr_load, 1'b1);
    wr(32'h8000_1f80, wr_restore, 1'b1);
    rd(rd_store, 32'h0000_1f80, 32'h0);
    wr(32'h0000_1fc0, wr_restore, 1'b0);
    chk(32'(nd_fault), 32'h1);
    chk(32'(zero_abnormal_inputs), 32'h1);
    $display("test reserved done");
    for (int i = 0; i < 4; i++) begin
      wr(32'h0000_1f80 | 32'(i << 13), wr_load, 1'b0);
      chk(32'(rounding_mode), 32'(i));
    end
    $display("test rounding done");
    for (int i = 0; i < 6; i++) begin
      wr(32'h0000_1f80, wr_load, 1'b0);
      u_dp.report(6'h1 << i, 32'h0, '0);
      chk(32'(exc_raise), 32'h0);
      u_dp.report(6'h0, 32'h0, '0);
      rd(rd_store, 32'h0000_1f80 | (32'h1 << i), 32'h0);
    end
    wr(32'h0000_1f80, wr_restore, 1'b0);
    chk(32'(exc_flags), 32'h0);
    wr(32'h0000_0001, wr_load, 1'b0);
    u_dp.report(6'h0, 32'h0, '0);
    chk(32'(exc_raise), 32'h0);
    for (int i = 0; i < 6; i++) begin
      wr(32'h0000_1f80 & ~(32'h80 << i), wr_load, 1'b0);
      u_dp.report(6'h3f & ~(6'h1 << i), 32'h0, '0);
      chk(32'(exc_raise), 32'h0);
      u_dp.report(6'h1 << i, 32'h0, '0);
      chk(32'(exc_raise), 32'h1);
    end
    $display("test flags done");
    wr(32'h0000_9f80, wr_load, 1'b0);
    chk(32'(flush_mode), 32'h1);
    u_dp.report(6'h10, 32'h8000_1234, '0);
    chk(res_out, 32'h8000_0000);
    chk(32'(res_valid), 32'h1);
    chk(32'(exc_flags), 32'h30);
    u_dp.report(6'h10, 32'h0000_1234, '0);
    chk(res_out, 32'h0);
    wr(32'h0000_9780, wr_load, 1'b0);
    u_dp.report(6'h10, 32'h8000_1234, '0);
    chk(res_out, 32'h8000_1234);
    chk(32'({exc_raise, exc_flags}), 32'h50);
    $display("test flush done");
    wr(32'h0000_1ec0, wr_load, 1'b0);
    u_dp.report(6'h02, 32'h0, {32'h8000_0001, 32'h0000_0010, 32'h3f80_0000, 32'h807f_ffff});
    chk(op_out[127:96], 32'h8000_0000);
    chk(op_out[95:64], 32'h0);
    chk(op_out[63:32], 32'h3f80_0000);
    chk(op_out[31:0], 32'h8000_0000);
    chk(32'({exc_raise, exc_flags}), 32'h0);
    $display("test zeroing done");
    wr(32'h0000_e07f, wr_load, 1'b0);
    @(posedge clk);
    #1;
    reset = 1'b1;
    repeat (3) @(posedge clk);
    #1;
    reset = 1'b0;
    chk(32'({exc_masks, exc_flags}), 32'h0000_0fc0);
    chk(32'({flush_mode, zero_abnormal_inputs, rounding_mode}), 32'h0);
    rd(rd_store, 32'h0000_1f80, 32'h0);
    $display("test reset again done");
    print_verdict();
  end
endmodule
